// *** pkg/gddn_map.vh ***
// Constants for the global data and datagram node.
// Assumes a 125 MHz system clock; included by bare name in hw/ files.
`ifndef GDDN_MAP_VH
`define GDDN_MAP_VH

`define GDDN_CLK_PERIOD_NS 8
`define GDDN_BYTE_SCAN_NS 72000
`define GDDN_BYTE_SCAN_CYC (`GDDN_BYTE_SCAN_NS / `GDDN_CLK_PERIOD_NS)
`define GDDN_MAX_BYTES 8'h80
`define GDDN_REF_LOW_MASK 16'h7fff
`define GDDN_TYPE_GD 8'h01
`define GDDN_TYPE_DG 8'h10
`define GDDN_GD_HDR_LEN 8'h05
`define GDDN_DG_HDR_LEN 8'h03
`define GDDN_MAX_RETRY 2'h3
`define GDDN_ACK_WAIT_CYC 16'h03e8
`define GDDN_CFG_REF_RST 16'h8000
`define GDDN_CFG_LEN_RST 8'h00

`endif

// *** hw/gddn_buf2.v ***
// Two-entry buffer between the node's byte sequencer and the bus link.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module gddn_buf2 #(
	parameter WIDTH = 9
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] ent0_r;
	reg [WIDTH-1:0] ent1_r;
	reg [1:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = ent0_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Entry 0 is always the head, so the output comes straight from a flop.
	always @(posedge clk) begin
		if (rst) begin
			ent0_r <= {WIDTH{1'b0}};
			ent1_r <= {WIDTH{1'b0}};
			cnt_r <= 2'h0;
		end else if (ce) begin
			if (pop) begin
				ent0_r <= ent1_r;
			end
			if (push) begin
				if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
					ent0_r <= in_data;
				end else begin
					ent1_r <= in_data;
				end
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 2'h1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 2'h1;
			end
		end
	end
endmodule

// *** hw/gddn_node.v ***
// Bus node that broadcasts a global data block each scan and sends
// directed or broadcast datagrams; received global data is filed by sender.
// Assumes one clock, a token pulse marking this node's bus access, and a
// link that consumes bytes through a valid/ready handshake.
`timescale 1ns/1ps
`include "gddn_map.vh"
module gddn_node #(
	parameter BYTE_SCAN_CYC = `GDDN_BYTE_SCAN_CYC,
	parameter ACK_WAIT_CYC = `GDDN_ACK_WAIT_CYC,
	parameter MAX_RETRY = `GDDN_MAX_RETRY
) (
	input wire CLK_SYS,
	input wire RST,
	input wire CE,
	input wire [4:0] NODE_ADDR,
	input wire LOAD_CFG,
	input wire [15:0] GLOBAL_DATA_BASE_REFERENCE,
	input wire [7:0] GLOBAL_DATA_BYTE_LENGTH,
	output wire CFG_CLAMPED,
	output wire [23:0] SCAN_EXTRA_CYC,
	input wire LOAD_GLOBAL_OUTPUT_BUFFER,
	input wire [6:0] OUT_IDX,
	input wire [7:0] OUT_DATA,
	input wire DG_WE,
	input wire [6:0] DG_IDX,
	input wire [7:0] DG_DATA,
	input wire DG_SEND,
	input wire [4:0] DG_DEST,
	input wire DG_DIRECTED,
	input wire DG_HIGH,
	input wire [7:0] DG_LEN,
	output wire DG_BUSY,
	output wire DG_DONE,
	output wire DG_ALARM,
	input wire BUS_TOKEN,
	output wire TX_VALID,
	input wire TX_READY,
	output wire [7:0] TX_DATA,
	output wire TX_LAST,
	input wire BUS_ACK,
	input wire BUS_NAK,
	input wire RX_GD_VALID,
	input wire [4:0] RX_SRC,
	input wire [6:0] RX_IDX,
	input wire [7:0] RX_DATA,
	output wire IN_WE,
	output wire [11:0] IN_ADDR,
	output wire [7:0] IN_DATA
);
	localparam ST_IDLE = 3'h0;
	localparam ST_GDH = 3'h1;
	localparam ST_GDD = 3'h2;
	localparam ST_DGH = 3'h3;
	localparam ST_DGD = 3'h4;
	localparam ST_WAIT = 3'h5;

	reg [15:0] cfg_ref_r;
	reg [7:0] cfg_len_r;
	reg cfg_ok_r, clamp_r;
	reg [23:0] scan_extra_r;
	reg [7:0] out_mem [0:127];
	reg [7:0] dg_mem [0:127];
	reg dg_pend_r, dg_busy_r;
	reg [4:0] dg_dest_r;
	reg dg_dir_r, dg_hi_r;
	reg [7:0] dg_len_r;
	reg [1:0] retry_r;
	reg [15:0] wait_r;
	reg [2:0] state_r;
	reg [7:0] cnt_r;
	reg last_dg_r, done_r, alarm_r, in_we_r;
	reg [11:0] in_addr_r;
	reg [7:0] in_data_r;
	reg push_valid, push_last;
	reg [7:0] push_data;
	wire push_ready, dg_allowed, gd_go;
	wire [31:0] scan_prod;

	// Clamps a requested byte count to the largest block the bus carries.
	function [7:0] clamp_len;
		input [7:0] len;
		begin
			clamp_len = (len > `GDDN_MAX_BYTES) ? `GDDN_MAX_BYTES : len;
		end
	endfunction

	function [7:0] gd_hdr;
		input [7:0] idx;
		input [4:0] src;
		input [15:0] ref_v;
		input [7:0] len;
		reg [15:0] reg_no;
		begin
			reg_no = ref_v & `GDDN_REF_LOW_MASK;
			case (idx[2:0])
			3'h0: gd_hdr = `GDDN_TYPE_GD;
			3'h1: gd_hdr = {3'h0, src};
			3'h2: gd_hdr = reg_no[15:8];
			3'h3: gd_hdr = reg_no[7:0];
			3'h4: gd_hdr = len;
			default: gd_hdr = 8'h00;
			endcase
		end
	endfunction

	assign CFG_CLAMPED = clamp_r;
	assign SCAN_EXTRA_CYC = scan_extra_r;
	assign DG_BUSY = dg_busy_r;
	assign DG_DONE = done_r;
	assign DG_ALARM = alarm_r;
	assign IN_WE = in_we_r;
	assign IN_ADDR = in_addr_r;
	assign IN_DATA = in_data_r;
	// Normal priority may ride only on an access that follows one without a
	// datagram, so it never lengthens two scans in a row.
	assign dg_allowed = dg_pend_r && (dg_hi_r || !last_dg_r);
	assign gd_go = cfg_ok_r && (cfg_len_r != 8'h00);
	assign scan_prod = clamp_len(GLOBAL_DATA_BYTE_LENGTH) *
		BYTE_SCAN_CYC;

	always @* begin
		push_valid = 1'b0;
		push_data = 8'h00;
		push_last = 1'b0;
		case (state_r)
		ST_GDH: begin
			push_valid = 1'b1;
			push_data = gd_hdr(cnt_r, NODE_ADDR, cfg_ref_r, cfg_len_r);
		end
		ST_GDD: begin
			push_valid = 1'b1;
			push_data = out_mem[cnt_r[6:0]];
			push_last = (cnt_r == cfg_len_r - 8'h01);
		end
		ST_DGH: begin
			push_valid = 1'b1;
			if (cnt_r == 8'h00) begin
				push_data = `GDDN_TYPE_DG | {6'h00, dg_hi_r, dg_dir_r};
			end else if (cnt_r == 8'h01) begin
				push_data = {3'h0, dg_dest_r};
			end else begin
				push_data = dg_len_r;
			end
			push_last = (cnt_r == `GDDN_DG_HDR_LEN - 8'h01) &&
				(dg_len_r == 8'h00);
		end
		ST_DGD: begin
			push_valid = 1'b1;
			push_data = dg_mem[cnt_r[6:0]];
			push_last = (cnt_r == dg_len_r - 8'h01);
		end
		default: push_valid = 1'b0;
		endcase
	end

	gddn_buf2 #(
		.WIDTH(9)
	) u_txbuf (
		.clk(CLK_SYS),
		.rst(RST),
		.ce(CE),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data({push_last, push_data}),
		.out_valid(TX_VALID),
		.out_ready(TX_READY),
		.out_data({TX_LAST, TX_DATA})
	);

	// Host-side storage has no reset; contents are defined once written.
	always @(posedge CLK_SYS) begin
		if (CE && LOAD_GLOBAL_OUTPUT_BUFFER) begin
			out_mem[OUT_IDX] <= OUT_DATA;
		end
		if (CE && DG_WE) begin
			dg_mem[DG_IDX] <= DG_DATA;
		end
	end

	always @(posedge CLK_SYS) begin
		if (RST) begin
			cfg_ref_r <= `GDDN_CFG_REF_RST;
			cfg_len_r <= `GDDN_CFG_LEN_RST;
			cfg_ok_r <= 1'b0;
			clamp_r <= 1'b0;
			scan_extra_r <= 24'h00_0000;
			in_we_r <= 1'b0;
			in_addr_r <= 12'h000;
			in_data_r <= 8'h00;
		end else if (CE) begin
			if (LOAD_CFG) begin
				// Reference is stored as given; gd_hdr masks off its top bit in the header.
				cfg_ref_r <= GLOBAL_DATA_BASE_REFERENCE;
				cfg_len_r <= clamp_len(GLOBAL_DATA_BYTE_LENGTH);
				clamp_r <= (GLOBAL_DATA_BYTE_LENGTH > `GDDN_MAX_BYTES);
				cfg_ok_r <= 1'b1;
				scan_extra_r <= scan_prod[23:0];
			end
			in_we_r <= RX_GD_VALID;
			if (RX_GD_VALID) begin
				in_addr_r <= {RX_SRC, RX_IDX};
				in_data_r <= RX_DATA;
			end
		end
	end

	always @(posedge CLK_SYS) begin
		if (RST) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
			last_dg_r <= 1'b0;
			dg_pend_r <= 1'b0;
			dg_busy_r <= 1'b0;
			dg_dest_r <= 5'h00;
			dg_dir_r <= 1'b0;
			dg_hi_r <= 1'b0;
			dg_len_r <= 8'h00;
			retry_r <= 2'h0;
			wait_r <= 16'h0000;
			done_r <= 1'b0;
			alarm_r <= 1'b0;
		end else if (CE) begin
			done_r <= 1'b0;
			alarm_r <= 1'b0;
			// A send request while busy is ignored, not queued.
			if (DG_SEND && !dg_busy_r) begin
				dg_pend_r <= 1'b1;
				dg_busy_r <= 1'b1;
				dg_dest_r <= DG_DEST;
				dg_dir_r <= DG_DIRECTED;
				dg_hi_r <= DG_HIGH;
				dg_len_r <= clamp_len(DG_LEN);
				retry_r <= 2'h0;
			end
			case (state_r)
			ST_IDLE: begin
				cnt_r <= 8'h00;
				if (BUS_TOKEN) begin
					if (gd_go) begin
						state_r <= ST_GDH;
					end else if (dg_allowed) begin
						state_r <= ST_DGH;
					end else begin
						last_dg_r <= 1'b0;
					end
				end
			end
			ST_GDH: begin
				if (push_ready) begin
					if (cnt_r == `GDDN_GD_HDR_LEN - 8'h01) begin
						state_r <= ST_GDD;
						cnt_r <= 8'h00;
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
			end
			ST_GDD: begin
				if (push_ready) begin
					if (push_last) begin
						cnt_r <= 8'h00;
						if (dg_allowed) begin
							state_r <= ST_DGH;
						end else begin
							state_r <= ST_IDLE;
							last_dg_r <= 1'b0;
						end
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
			end
			ST_DGH: begin
				if (push_ready) begin
					cnt_r <= 8'h00;
					if (cnt_r != `GDDN_DG_HDR_LEN - 8'h01) begin
						cnt_r <= cnt_r + 8'h01;
					end else if (dg_len_r != 8'h00) begin
						state_r <= ST_DGD;
					end
				end
			end
			ST_DGD: begin
				if (push_ready) begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
			ST_WAIT: begin
				wait_r <= wait_r + 16'h0001;
				if (BUS_ACK) begin
					state_r <= ST_IDLE;
					dg_busy_r <= 1'b0;
					done_r <= 1'b1;
				end else if (BUS_NAK || wait_r == ACK_WAIT_CYC - 16'h0001) begin
					state_r <= ST_IDLE;
					if (retry_r == MAX_RETRY) begin
						dg_busy_r <= 1'b0;
						alarm_r <= 1'b1;
					end else begin
						retry_r <= retry_r + 2'h1;
						dg_pend_r <= 1'b1;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
			// End of a datagram, shared by the header-only and data cases.
			if ((state_r == ST_DGH || state_r == ST_DGD) && push_ready &&
				push_last) begin
				dg_pend_r <= 1'b0;
				last_dg_r <= 1'b1;
				cnt_r <= 8'h00;
				wait_r <= 16'h0000;
				if (dg_dir_r) begin
					state_r <= ST_WAIT;
				end else begin
					state_r <= ST_IDLE;
					dg_busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end
endmodule

// *** testbench/gddn_node_assertions.sv ***
// Port checker for the global data and datagram node.
// Assumes one clock with synchronous reset; bound to every gddn_node.
`timescale 1ns/1ps
module gddn_node_chk #(
	parameter BYTE_SCAN_CYC = 9000
) (
	input wire CLK_SYS,
	input wire RST,
	input wire CE,
	input wire LOAD_CFG,
	input wire [7:0] GLOBAL_DATA_BYTE_LENGTH,
	input wire CFG_CLAMPED,
	input wire [23:0] SCAN_EXTRA_CYC,
	input wire DG_SEND,
	input wire DG_BUSY,
	input wire DG_DONE,
	input wire DG_ALARM,
	input wire TX_VALID,
	input wire TX_READY,
	input wire [7:0] TX_DATA,
	input wire TX_LAST,
	input wire RX_GD_VALID,
	input wire [4:0] RX_SRC,
	input wire [6:0] RX_IDX,
	input wire [7:0] RX_DATA,
	input wire IN_WE,
	input wire [11:0] IN_ADDR,
	input wire [7:0] IN_DATA
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	sequence s_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence s_held;
		TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
	endsequence
	a_cfg_clamp: assert property (LOAD_CFG && CE |=> CFG_CLAMPED ==
		($past(GLOBAL_DATA_BYTE_LENGTH) > 8'h80)) else $error("clamp flag");
	a_scan_growth: assert property (LOAD_CFG && CE |=> SCAN_EXTRA_CYC ==
		24'((($past(GLOBAL_DATA_BYTE_LENGTH) > 8'h80) ? 8'h80 :
		$past(GLOBAL_DATA_BYTE_LENGTH)) * BYTE_SCAN_CYC))
		else $error("scan growth");
	a_dg_accept: assert property (DG_SEND && !DG_BUSY && CE |=> DG_BUSY)
		else $error("busy missing");
	a_done_pulse: assert property (DG_DONE && CE |=> !DG_DONE)
		else $error("done too long");
	a_end_excl: assert property (!(DG_DONE && DG_ALARM))
		else $error("done with alarm");
	a_tx_hold: assert property (s_stall |=> s_held)
		else $error("byte lost in stall");
	a_rx_file: assert property (RX_GD_VALID && CE |=> IN_WE &&
		IN_ADDR == {$past(RX_SRC), $past(RX_IDX)} &&
		IN_DATA == $past(RX_DATA)) else $error("rx filing");
	a_we_cause: assert property (IN_WE |-> $past(RX_GD_VALID))
		else $error("stray write");
endmodule
bind gddn_node gddn_node_chk #(
	.BYTE_SCAN_CYC(BYTE_SCAN_CYC)
) u_gddn_node_chk (
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.CE(CE),
	.LOAD_CFG(LOAD_CFG),
	.GLOBAL_DATA_BYTE_LENGTH(GLOBAL_DATA_BYTE_LENGTH),
	.CFG_CLAMPED(CFG_CLAMPED),
	.SCAN_EXTRA_CYC(SCAN_EXTRA_CYC),
	.DG_SEND(DG_SEND),
	.DG_BUSY(DG_BUSY),
	.DG_DONE(DG_DONE),
	.DG_ALARM(DG_ALARM),
	.TX_VALID(TX_VALID),
	.TX_READY(TX_READY),
	.TX_DATA(TX_DATA),
	.TX_LAST(TX_LAST),
	.RX_GD_VALID(RX_GD_VALID),
	.RX_SRC(RX_SRC),
	.RX_IDX(RX_IDX),
	.RX_DATA(RX_DATA),
	.IN_WE(IN_WE),
	.IN_ADDR(IN_ADDR),
	.IN_DATA(IN_DATA)
);

// *** testbench/gddn_link_model.sv ***
// Far end of the link: takes node bytes, answers directed datagrams.
// Assumes one clock; slow toggles ready, nak refuses every directed datagram.
`timescale 1ns/1ps
module gddn_link_model (
	input wire clk,
	input wire rst,
	input wire slow,
	input wire nak,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_last,
	output reg tx_ready,
	output reg bus_ack,
	output reg bus_nak
);
	logic [7:0] b [0:511];
	int n;
	int nf;
	logic first;
	logic dir_r;
	always @(posedge clk) begin
		bus_ack <= 1'b0;
		bus_nak <= 1'b0;
		if (rst) begin
			n <= 0;
			nf <= 0;
			first <= 1'b1;
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? !tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				b[n] <= tx_data;
				n <= n + 1;
				first <= tx_last;
				if (first)
					dir_r <= tx_data[4] && tx_data[0];
				if (tx_last) begin
					nf <= nf + 1;
					// Only a directed frame is answered.
					bus_ack <= !nak && (first ? tx_data[0] : dir_r);
					bus_nak <= nak && (first ? tx_data[0] : dir_r);
				end
			end
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the global data and datagram node.
// Assumes gddn_link_model at the link and the bound port checker.
`timescale 1ns/1ps
module testbench;
	localparam int BSC = 4;
	logic clk = 0, rst = 1, ld = 0, obw = 0, dgw = 0, dgs = 0, dir = 0;
	logic hi = 0, tok = 0, rxv = 0, slow = 0, nak = 0, ce = 1;
	logic [15:0] ref_v = 0;
	logic [7:0] len = 0, od = 0, dd = 0, dlen = 0, rxd = 0;
	logic [6:0] oi = 0, di = 0, rxi = 0;
	logic [4:0] dst = 0, rxs = 0;
	wire clamped, busy, done, alarm, txv, txr, txl, ack, nk, we;
	wire [23:0] extra;
	wire [7:0] txd, idt;
	wire [11:0] ia;
	int failures = 0, num_checks = 0, cyc = 0, s, k;
	int n_done = 0, n_alarm = 0, d0, a0;
	gddn_node #(.BYTE_SCAN_CYC(BSC)) u_gddn_node (.CLK_SYS(clk), .RST(rst),
		.CE(ce), .NODE_ADDR(5'h1e), .LOAD_CFG(ld),
		.GLOBAL_DATA_BASE_REFERENCE(ref_v), .GLOBAL_DATA_BYTE_LENGTH(len),
		.CFG_CLAMPED(clamped), .SCAN_EXTRA_CYC(extra),
		.LOAD_GLOBAL_OUTPUT_BUFFER(obw), .OUT_IDX(oi), .OUT_DATA(od),
		.DG_WE(dgw), .DG_IDX(di), .DG_DATA(dd), .DG_SEND(dgs), .DG_DEST(dst),
		.DG_DIRECTED(dir), .DG_HIGH(hi), .DG_LEN(dlen), .DG_BUSY(busy),
		.DG_DONE(done), .DG_ALARM(alarm), .BUS_TOKEN(tok), .TX_VALID(txv),
		.TX_READY(txr), .TX_DATA(txd), .TX_LAST(txl), .BUS_ACK(ack),
		.BUS_NAK(nk), .RX_GD_VALID(rxv), .RX_SRC(rxs), .RX_IDX(rxi),
		.RX_DATA(rxd), .IN_WE(we), .IN_ADDR(ia), .IN_DATA(idt));
	gddn_link_model u_gddn_link_model (.clk(clk), .rst(rst), .slow(slow),
		.nak(nak), .tx_valid(txv), .tx_data(txd), .tx_last(txl),
		.tx_ready(txr), .bus_ack(ack), .bus_nak(nk));
	initial forever #4 clk = ~clk;
	task final_report;
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Done and alarm are one-cycle pulses; a broadcast's done can fall
	// before the link has taken its last byte, so every pulse is counted.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1)
			n_done <= n_done + 1;
		if (alarm === 1'b1)
			n_alarm <= n_alarm + 1;
		if (cyc == 60000) begin
			failures++;
			final_report;
		end
	end
	task tick(input int t);
		repeat (t) @(posedge clk);
		#1;
	endtask
	task chk(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task exp_bytes(input int st, input logic [7:0] e [$]);
		foreach (e[i])
			chk(u_gddn_link_model.b[st + i], e[i]);
	endtask
	// Tries a few accesses, since normal priority may skip one.
	task frame(output int st);
		int f;
		st = u_gddn_link_model.n;
		f = u_gddn_link_model.nf;
		for (int t = 0; t < 4 && u_gddn_link_model.nf == f; t++) begin
			tok = 1;
			tick(1);
			tok = 0;
			for (int w = 0; w < 400 && u_gddn_link_model.nf == f; w++)
				tick(1);
		end
		chk(u_gddn_link_model.nf - f, 1);
	endtask
	task set_cfg(input logic [15:0] r, input logic [7:0] l);
		ref_v = r;
		len = l;
		ld = 1;
		tick(1);
		ld = 0;
		tick(1);
	endtask
	task t_global;
		set_cfg(16'hc123, 8'h03);
		chk(clamped, 0);
		chk(extra, 3 * BSC);
		for (int i = 0; i < 3; i++) begin
			oi = i;
			od = 8'ha0 + i;
			obw = 1;
			tick(1);
		end
		obw = 0;
		slow = 1;
		frame(s);
		exp_bytes(s, '{8'h01, 8'h1e, 8'h41, 8'h23, 8'h03, 8'ha0, 8'ha1, 8'ha2});
		oi = 1;
		od = 8'h5b;
		obw = 1;
		tick(1);
		obw = 0;
		slow = 0;
		frame(s);
		chk(u_gddn_link_model.b[s + 6], 8'h5b);
	endtask
	task t_clamp;
		set_cfg(16'h8000, 8'hc8);
		chk(clamped, 1);
		chk(extra, 128 * BSC);
		ce = 0;
		set_cfg(16'h8000, 8'h80);
		chk(clamped, 1);
		ce = 1;
		set_cfg(16'h8000, 8'h80);
		chk(clamped, 0);
		chk(extra, 128 * BSC);
	endtask
	task dg_run(input logic dv, hv, nv, input int nexp);
		nak = nv;
		dir = dv;
		hi = hv;
		dst = 5'h07;
		dlen = 8'h02;
		dgs = 1;
		tick(1);
		dgs = 0;
		chk(busy, 1);
		d0 = n_done;
		a0 = n_alarm;
		k = 0;
		while (k < 6 && n_done == d0 && n_alarm == a0) begin
			frame(s);
			k++;
			exp_bytes(s, '{8'h10 | {hv, dv}, 8'h07, 8'h02, 8'h3c, 8'hc3});
			for (int w = 0; w < 1200 && n_done == d0 && n_alarm == a0; w++)
				tick(1);
		end
		chk(k, nexp);
		chk(n_done - d0, !nv);
		chk(n_alarm - a0, nv);
	endtask
	task t_dg;
		set_cfg(16'h8000, 8'h00);
		for (int i = 0; i < 2; i++) begin
			di = i;
			dd = i ? 8'hc3 : 8'h3c;
			dgw = 1;
			tick(1);
		end
		dgw = 0;
		dg_run(1, 0, 0, 1);
		dg_run(0, 1, 0, 1);
		dg_run(1, 1, 1, 4);
	endtask
	task t_rx;
		for (int i = 0; i < 2; i++) begin
			rxs = i ? 5'h1f : 5'h03;
			rxi = i ? 7'h7f : 7'h02;
			rxd = 8'h9d + i;
			rxv = 1;
			tick(1);
			rxv = 0;
			chk(we, 1);
			chk(ia, i ? 12'hfff : 12'h182);
			chk(idt, 8'h9d + i);
		end
	endtask
	initial begin
		tick(10);
		rst = 0;
		t_global;
		t_clamp;
		t_dg;
		t_rx;
		final_report;
	end
endmodule
